/* File: include/sla_pkg.sv */
// constants, command encodings and register map of the shift and logic unit
package sla_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_ACC   = 8'h00;
    localparam logic [7:0] ADR_FLAGS = 8'h01;
    localparam logic [7:0] ADR_PORTA = 8'h02;
    localparam logic [7:0] ADR_IMM   = 8'h03;
    localparam logic [7:0] ADR_MIDX  = 8'h04;
    localparam logic [7:0] ADR_CMD   = 8'h05;
    localparam logic [3:0] ADR_MEM_HI = 4'h1;
    localparam int         MEM_DEPTH = 16;
    // ------------------------------------------------------------
    // flag positions and reset values
    // ------------------------------------------------------------
    localparam int         FLG_C  = 0;
    localparam int         FLG_Z  = 1;
    localparam int         FLG_AC = 2;
    localparam int         FLG_OV = 3;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [3:0] RST_IDX   = 4'h0;
    // ------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_DST_LSB = 4;
    localparam int CMD_SRC_LSB = 6;
    typedef enum logic [3:0]
    {
        OP_NOP  = 4'h0,
        OP_SHR  = 4'h1,
        OP_RRC  = 4'h2,
        OP_SHL  = 4'h3,
        OP_RLC  = 4'h4,
        OP_SWAP = 4'h5,
        OP_AND  = 4'h6,
        OP_OR   = 4'h7,
        OP_XOR  = 4'h8
    } sla_op_e;
    typedef enum logic [1:0]
    {
        LOC_ACC = 2'h0,
        LOC_MEM = 2'h1,
        LOC_IO  = 2'h2,
        LOC_IMM = 2'h3
    } sla_loc_e;
endpackage

/* File: include/sla_if.sv */
// operand and result signals between the top and the operation unit
`timescale 1ns/10ps
`default_nettype none
interface sla_if;
    sla_pkg::sla_op_e op;
    logic [7:0]       opa;
    logic [7:0]       opb;
    logic             cin;
    logic [7:0]       res;
    logic             cout;
    logic             zero;
    logic             upd_c;
    logic             upd_z;
    modport core (output op, output opa, output opb, output cin,
                  input res, input cout, input zero, input upd_c, input upd_z);
    modport unit (input op, input opa, input opb, input cin,
                  output res, output cout, output zero, output upd_c, output upd_z);
endinterface
`default_nettype wire

/* File: design/sla_unit.sv */
// combinational result and flag-update generator
`timescale 1ns/10ps
`default_nettype none
module sla_unit
(
    sla_if.unit u
);
    // ------------------------------------------------------------
    // result and carry per operation
    // ------------------------------------------------------------
    always_comb
    begin
        u.res   = u.opa;
        u.cout  = u.cin;
        u.upd_c = 1'b0;
        u.upd_z = 1'b0;
        case (u.op)
            sla_pkg::OP_SHR:
            begin
                u.res   = {1'b0, u.opa[7:1]};
                u.cout  = u.opa[0];
                u.upd_c = 1'b1;
            end
            sla_pkg::OP_RRC:
            begin
                u.res   = {u.cin, u.opa[7:1]};
                u.cout  = u.opa[0];
                u.upd_c = 1'b1;
            end
            sla_pkg::OP_SHL:
            begin
                u.res   = {u.opa[6:0], 1'b0};
                u.cout  = u.opa[7];
                u.upd_c = 1'b1;
            end
            sla_pkg::OP_RLC:
            begin
                u.res   = {u.opa[6:0], u.cin};
                u.cout  = u.opa[7];
                u.upd_c = 1'b1;
            end
            sla_pkg::OP_SWAP:
                u.res = {u.opa[3:0], u.opa[7:4]};
            sla_pkg::OP_AND:
            begin
                u.res   = u.opa & u.opb;
                u.upd_z = 1'b1;
            end
            sla_pkg::OP_OR:
            begin
                u.res   = u.opa | u.opb;
                u.upd_z = 1'b1;
            end
            sla_pkg::OP_XOR:
            begin
                u.res   = u.opa ^ u.opb;
                u.upd_z = 1'b1;
            end
            default:
                u.res = u.opa;
        endcase
        u.zero = (u.res == 8'h00);
    end
endmodule
`default_nettype wire

/* File: design/sla_top.sv */
// shift, rotate, swap and bitwise logic datapath with register port
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sla_top
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic      [7:0] acc_out,
    output logic      [3:0] flags_out,
    output logic      [7:0] port_a_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [15:0][7:0] mem;
        logic [7:0]       acc;
        logic [7:0]       port_a_latch;
        logic [7:0]       imm;
        logic [3:0]       midx;
        logic [7:0]       cmd;
        logic             bit_out_reg;
        logic             result_null_flag;
        logic             half_borrow_bit;
        logic             signed_wrap_bit;
        logic [7:0]       rdata;
    } sla_state_s;

    sla_state_s st;
    sla_state_s next_st;
    sla_if      ui ();

    sla_unit u_unit
    (
        .u (ui.unit)
    );

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    sla_pkg::sla_op_e  cmd_op;
    sla_pkg::sla_loc_e cmd_dst;
    sla_pkg::sla_loc_e cmd_src;
    logic              is_shift;
    logic              is_andor;
    logic              legal;
    logic              go;
    logic [7:0]        mem_byte;
    logic [7:0]        target;
    logic [3:0]        flag_vec;

    assign cmd_op   = sla_pkg::sla_op_e'(reg_wdata[sla_pkg::CMD_OP_LSB +: 4]);
    assign cmd_dst  = sla_pkg::sla_loc_e'(reg_wdata[sla_pkg::CMD_DST_LSB +: 2]);
    assign cmd_src  = sla_pkg::sla_loc_e'(reg_wdata[sla_pkg::CMD_SRC_LSB +: 2]);
    assign mem_byte = st.mem[st.midx];
    assign is_shift = (cmd_op == sla_pkg::OP_SHR) || (cmd_op == sla_pkg::OP_RRC)
                   || (cmd_op == sla_pkg::OP_SHL) || (cmd_op == sla_pkg::OP_RLC)
                   || (cmd_op == sla_pkg::OP_SWAP);
    assign is_andor = (cmd_op == sla_pkg::OP_AND) || (cmd_op == sla_pkg::OP_OR);

    // illegal combinations are dropped rather than guessed at
    always_comb
    begin
        legal = 1'b0;
        if (is_shift)
            legal = (cmd_dst == sla_pkg::LOC_ACC) || (cmd_dst == sla_pkg::LOC_MEM);
        else if (is_andor || (cmd_op == sla_pkg::OP_XOR))
        begin
            if (cmd_dst == sla_pkg::LOC_MEM)
                legal = 1'b1;
            else if (cmd_dst == sla_pkg::LOC_IO)
                legal = (cmd_op == sla_pkg::OP_XOR);
            else if (cmd_dst == sla_pkg::LOC_ACC)
                legal = (cmd_src == sla_pkg::LOC_IMM) || (cmd_src == sla_pkg::LOC_MEM)
                     || ((cmd_src == sla_pkg::LOC_IO) && !is_andor);
        end
    end

    assign go = reg_wr && (reg_addr == sla_pkg::ADR_CMD) && legal;

    // ------------------------------------------------------------
    // operand selection
    // ------------------------------------------------------------
    always_comb
    begin
        target = st.acc;
        if (cmd_dst == sla_pkg::LOC_MEM)
            target = mem_byte;
        else if (cmd_dst == sla_pkg::LOC_IO)
            target = st.port_a_latch;
        ui.op  = go ? cmd_op : sla_pkg::OP_NOP;
        ui.cin = st.bit_out_reg;
        ui.opa = is_shift ? target : st.acc;
        if (cmd_dst != sla_pkg::LOC_ACC)
            ui.opb = target;
        else if (cmd_src == sla_pkg::LOC_MEM)
            ui.opb = mem_byte;
        else if (cmd_src == sla_pkg::LOC_IO)
            ui.opb = st.port_a_latch;
        else
            ui.opb = st.imm;
    end

    // ------------------------------------------------------------
    // next state: register port and execution
    // ------------------------------------------------------------
    always_comb
    begin
        next_st       = st;
        next_st.rdata = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == sla_pkg::ADR_ACC)
                next_st.rdata = st.acc;
            else if (reg_addr == sla_pkg::ADR_FLAGS)
                next_st.rdata = {4'h0, flag_vec};
            else if (reg_addr == sla_pkg::ADR_PORTA)
                next_st.rdata = st.port_a_latch;
            else if (reg_addr == sla_pkg::ADR_IMM)
                next_st.rdata = st.imm;
            else if (reg_addr == sla_pkg::ADR_MIDX)
                next_st.rdata = {4'h0, st.midx};
            else if (reg_addr == sla_pkg::ADR_CMD)
                next_st.rdata = st.cmd;
            else if (reg_addr[7:4] == sla_pkg::ADR_MEM_HI)
                next_st.rdata = st.mem[reg_addr[3:0]];
        end
        if (reg_wr)
        begin
            if (reg_addr == sla_pkg::ADR_ACC)
                next_st.acc = reg_wdata;
            else if (reg_addr == sla_pkg::ADR_FLAGS)
            begin
                next_st.bit_out_reg      = reg_wdata[sla_pkg::FLG_C];
                next_st.result_null_flag = reg_wdata[sla_pkg::FLG_Z];
                next_st.half_borrow_bit  = reg_wdata[sla_pkg::FLG_AC];
                next_st.signed_wrap_bit  = reg_wdata[sla_pkg::FLG_OV];
            end
            else if (reg_addr == sla_pkg::ADR_PORTA)
                next_st.port_a_latch = reg_wdata;
            else if (reg_addr == sla_pkg::ADR_IMM)
                next_st.imm = reg_wdata;
            else if (reg_addr == sla_pkg::ADR_MIDX)
                next_st.midx = reg_wdata[3:0];
            else if (reg_addr == sla_pkg::ADR_CMD)
                next_st.cmd = reg_wdata;
            else if (reg_addr[7:4] == sla_pkg::ADR_MEM_HI)
                next_st.mem[reg_addr[3:0]] = reg_wdata;
        end
        if (go)
        begin
            // result goes back where the destination field points
            if (cmd_dst == sla_pkg::LOC_MEM)
                next_st.mem[st.midx] = ui.res;
            else if (cmd_dst == sla_pkg::LOC_IO)
                next_st.port_a_latch = ui.res;
            else
                next_st.acc = ui.res;
            if (ui.upd_c)
                next_st.bit_out_reg = ui.cout;
            // xor into the port must leave the zero flag alone
            if (ui.upd_z && (cmd_dst != sla_pkg::LOC_IO))
                next_st.result_null_flag = ui.zero;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            st                  <= '0;
            st.acc              <= sla_pkg::RST_BYTE;
            st.port_a_latch     <= sla_pkg::RST_BYTE;
            st.imm              <= sla_pkg::RST_BYTE;
            st.cmd              <= sla_pkg::RST_BYTE;
            st.rdata            <= sla_pkg::RST_BYTE;
            st.midx             <= sla_pkg::RST_IDX;
            {st.signed_wrap_bit, st.half_borrow_bit,
             st.result_null_flag, st.bit_out_reg} <= sla_pkg::RST_FLAGS;
        end
        else
            st <= next_st;
    end

    always_comb
    begin
        flag_vec                  = 4'h0;
        flag_vec[sla_pkg::FLG_C]  = st.bit_out_reg;
        flag_vec[sla_pkg::FLG_Z]  = st.result_null_flag;
        flag_vec[sla_pkg::FLG_AC] = st.half_borrow_bit;
        flag_vec[sla_pkg::FLG_OV] = st.signed_wrap_bit;
    end

    // outputs come straight from the state flip-flops
    assign reg_rdata  = st.rdata;
    assign acc_out    = st.acc;
    assign flags_out  = flag_vec;
    assign port_a_out = st.port_a_latch;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_go_acc(logic [3:0] o);
        go && (cmd_op == o) && (cmd_dst == sla_pkg::LOC_ACC);
    endsequence

    sequence s_go_mem(logic [3:0] o);
        go && (cmd_op == o) && (cmd_dst == sla_pkg::LOC_MEM);
    endsequence

    property p_shr_acc;
        s_go_acc(sla_pkg::OP_SHR) |=>
            {st.acc, st.bit_out_reg} == {1'b0, $past(st.acc)};
    endproperty
    a_shr_acc: assert property (p_shr_acc) else $error("shift right wrong");

    property p_rrc_acc;
        s_go_acc(sla_pkg::OP_RRC) |=>
            {st.acc, st.bit_out_reg} == {$past(st.bit_out_reg), $past(st.acc)};
    endproperty
    a_rrc_acc: assert property (p_rrc_acc) else $error("rotate right wrong");

    property p_shl_acc;
        s_go_acc(sla_pkg::OP_SHL) |=>
            {st.bit_out_reg, st.acc} == {$past(st.acc), 1'b0};
    endproperty
    a_shl_acc: assert property (p_shl_acc) else $error("shift left wrong");

    property p_rlc_mem;
        s_go_mem(sla_pkg::OP_RLC) |=>
            {st.bit_out_reg, st.mem[$past(st.midx)]}
                == {$past(mem_byte), $past(st.bit_out_reg)};
    endproperty
    a_rlc_mem: assert property (p_rlc_mem) else $error("rotate left wrong");

    property p_shift_flags;
        go && is_shift |=> $stable(st.result_null_flag) && $stable(st.half_borrow_bit)
                           && $stable(st.signed_wrap_bit);
    endproperty
    a_shift_flags: assert property (p_shift_flags) else $error("shift hit flags");

    property p_swap;
        s_go_acc(sla_pkg::OP_SWAP) |=>
            st.acc == {$past(st.acc[3:0]), $past(st.acc[7:4])} && $stable(flag_vec);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_and_mem;
        s_go_mem(sla_pkg::OP_AND) |=>
            st.mem[$past(st.midx)] == ($past(st.acc) & $past(mem_byte))
            && $stable(st.bit_out_reg) && $stable(st.half_borrow_bit);
    endproperty
    a_and_mem: assert property (p_and_mem) else $error("and to memory wrong");

    property p_or_imm;
        s_go_acc(sla_pkg::OP_OR) ##0 (cmd_src == sla_pkg::LOC_IMM) |=>
            st.acc == ($past(st.acc) | $past(st.imm)) && $stable(st.signed_wrap_bit);
    endproperty
    a_or_imm: assert property (p_or_imm) else $error("or immediate wrong");

    property p_xor_imm;
        s_go_acc(sla_pkg::OP_XOR) ##0 (cmd_src == sla_pkg::LOC_IMM) |=>
            st.acc == ($past(st.acc) ^ $past(st.imm)) && $stable(st.bit_out_reg);
    endproperty
    a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");

    property p_xor_io_acc;
        s_go_acc(sla_pkg::OP_XOR) ##0 (cmd_src == sla_pkg::LOC_IO) |=>
            st.acc == ($past(st.acc) ^ $past(st.port_a_latch)) && $stable(st.port_a_latch);
    endproperty
    a_xor_io_acc: assert property (p_xor_io_acc) else $error("xor from port wrong");

    property p_xor_io_dst;
        go && (cmd_op == sla_pkg::OP_XOR) && (cmd_dst == sla_pkg::LOC_IO) |=>
            st.port_a_latch == ($past(st.acc) ^ $past(st.port_a_latch))
            && $stable(flag_vec) && $stable(st.acc);
    endproperty
    a_xor_io_dst: assert property (p_xor_io_dst) else $error("xor to port wrong");

    property p_zero;
        go && (is_andor || (cmd_op == sla_pkg::OP_XOR && cmd_dst != sla_pkg::LOC_IO))
        |=> st.result_null_flag == (st.acc == 8'h00 && $past(cmd_dst)
            == sla_pkg::LOC_ACC || $past(cmd_dst) == sla_pkg::LOC_MEM
            && st.mem[$past(st.midx)] == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_xor_mem;
        s_go_mem(sla_pkg::OP_XOR) |=>
            st.mem[$past(st.midx)] == ($past(st.acc) ^ $past(mem_byte))
            && $stable(st.acc) && $stable(st.bit_out_reg);
    endproperty
    a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

    property p_xor_accm;
        s_go_acc(sla_pkg::OP_XOR) ##0 (cmd_src == sla_pkg::LOC_MEM) |=>
            st.acc == ($past(st.acc) ^ $past(mem_byte)) && $stable(st.half_borrow_bit);
    endproperty
    a_xor_accm: assert property (p_xor_accm) else $error("xor from memory wrong");

    property p_and_accm;
        s_go_acc(sla_pkg::OP_AND) ##0 (cmd_src == sla_pkg::LOC_MEM) |=>
            st.acc == ($past(st.acc) & $past(mem_byte)) && $stable(st.signed_wrap_bit);
    endproperty
    a_and_accm: assert property (p_and_accm) else $error("and from memory wrong");

    property p_or_mem;
        s_go_mem(sla_pkg::OP_OR) |=>
            st.mem[$past(st.midx)] == ($past(st.acc) | $past(mem_byte))
            && $stable(st.bit_out_reg) && $stable(st.acc);
    endproperty
    a_or_mem: assert property (p_or_mem) else $error("or to memory wrong");

    property p_shr_mem;
        s_go_mem(sla_pkg::OP_SHR) |=>
            {st.mem[$past(st.midx)], st.bit_out_reg} == {1'b0, $past(mem_byte)}
            && $stable(st.result_null_flag);
    endproperty
    a_shr_mem: assert property (p_shr_mem) else $error("shift right memory wrong");
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the shift and logic unit with a reference model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ------------------------------------------------------------
    // stimulus, design and model state
    // ------------------------------------------------------------
    logic       sys_clk     = 1'b0;
    logic       resetn      = 1'b0;
    logic [7:0] reg_addr    = 8'h00;
    logic [7:0] reg_wdata   = 8'h00;
    logic       reg_wr      = 1'b0;
    logic       reg_rd      = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] acc_out;
    logic [3:0] flags_out;
    logic [7:0] port_a_out;
    int         miscompares = 0;
    int         n_tests     = 0;
    int         cycles      = 0;
    int         seed        = 23;
    logic [7:0] m_acc;
    logic [7:0] m_port;
    logic [7:0] m_imm;
    logic [7:0] m_cmd;
    logic [3:0] m_flg;
    logic [3:0] m_idx;
    logic [7:0] m_mem [16];
    logic       legal_map [256];
    logic [7:0] legal_q [$];
    logic [7:0] logic_cmds [11] = '{8'h46, 8'hC6, 8'h16, 8'h47, 8'hC7, 8'h17,
                                    8'h48, 8'h88, 8'hC8, 8'h18, 8'h28};
    // illegal words: nop, unknown op, and without source, swap and and to port
    logic [7:0] bad_cmds [5]    = '{8'h00, 8'h09, 8'h06, 8'h25, 8'h26};
    logic [7:0] probe [9]       = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                                    8'h06, 8'h20, 8'hFF};

    initial
        forever #20 sys_clk = ~sys_clk;

    sla_top uut
    (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .acc_out    (acc_out),
        .flags_out  (flags_out),
        .port_a_out (port_a_out)
    );

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    task automatic m_reset;
        m_acc  = 8'h00;
        m_port = 8'h00;
        m_imm  = 8'h00;
        m_cmd  = 8'h00;
        m_flg  = 4'h0;
        m_idx  = 4'h0;
        foreach (m_mem[k])
            m_mem[k] = 8'h00;
    endtask

    // illegal words are stored but leave every other register alone
    task automatic m_exec(input logic [7:0] cmd);
        logic [3:0] op;
        logic [1:0] dst;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] r;
        op  = cmd[3:0];
        dst = cmd[5:4];
        a   = (dst == 2'h0) ? m_acc : (dst == 2'h1) ? m_mem[m_idx] : m_port;
        b   = (dst != 2'h0) ? m_acc : (cmd[7:6] == 2'h1) ? m_mem[m_idx] :
              (cmd[7:6] == 2'h2) ? m_port : m_imm;
        if (!legal_map[cmd])
            return;
        case (op)
            4'h1:    r = {1'b0, a[7:1]};
            4'h2:    r = {m_flg[0], a[7:1]};
            4'h3:    r = {a[6:0], 1'b0};
            4'h4:    r = {a[6:0], m_flg[0]};
            4'h5:    r = {a[3:0], a[7:4]};
            4'h6:    r = a & b;
            4'h7:    r = a | b;
            default: r = a ^ b;
        endcase
        if (op <= 4'h4)
            m_flg[0] = (op <= 4'h2) ? a[0] : a[7];
        if (op >= 4'h6 && dst != 2'h2)
            m_flg[1] = (r == 8'h00);
        if (dst == 2'h0)
            m_acc = r;
        else if (dst == 2'h1)
            m_mem[m_idx] = r;
        else
            m_port = r;
    endtask

    task automatic m_write(input logic [7:0] addr, input logic [7:0] d);
        case (addr)
            sla_pkg::ADR_ACC:   m_acc = d;
            sla_pkg::ADR_FLAGS: m_flg = d[3:0];
            sla_pkg::ADR_PORTA: m_port = d;
            sla_pkg::ADR_IMM:   m_imm = d;
            sla_pkg::ADR_MIDX:  m_idx = d[3:0];
            sla_pkg::ADR_CMD:
            begin
                m_cmd = d;
                m_exec(d);
            end
            default:
                if (addr[7:4] == sla_pkg::ADR_MEM_HI)
                    m_mem[addr[3:0]] = d;
        endcase
    endtask

    function automatic logic [7:0] m_read(input logic [7:0] addr);
        case (addr)
            sla_pkg::ADR_ACC:   return m_acc;
            sla_pkg::ADR_FLAGS: return {4'h0, m_flg};
            sla_pkg::ADR_PORTA: return m_port;
            sla_pkg::ADR_IMM:   return m_imm;
            sla_pkg::ADR_MIDX:  return {4'h0, m_idx};
            sla_pkg::ADR_CMD:   return m_cmd;
            default:
                return (addr[7:4] == sla_pkg::ADR_MEM_HI) ? m_mem[addr[3:0]] : 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        m_write(addr, data);
    endtask

    // read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        data = reg_rdata;
    endtask

    task automatic check_outputs;
        check(acc_out, m_acc);
        check({4'h0, flags_out}, {4'h0, m_flg});
        check(port_a_out, m_port);
    endtask

    task automatic check_regs;
        logic [7:0] d;
        foreach (probe[k])
        begin
            rd(probe[k], d);
            check(d, m_read(probe[k]));
        end
        rd({sla_pkg::ADR_MEM_HI, m_idx}, d);
        check(d, m_mem[m_idx]);
    endtask

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // about 36 cycles per pass, so this ceiling leaves ample room
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            finish_test;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] cmd;
        foreach (legal_map[k])
            legal_map[k] = 1'b0;
        for (int op = 1; op <= 5; op++)
        begin
            legal_q.push_back({4'h0, 4'(op)});
            legal_q.push_back({4'h1, 4'(op)});
        end
        foreach (logic_cmds[k])
            legal_q.push_back(logic_cmds[k]);
        foreach (legal_q[k])
            legal_map[legal_q[k]] = 1'b1;
        m_reset();
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        check_outputs();
        wr(8'h06, 8'hA5);
        wr(8'h20, 8'h5A);
        wr(8'hFF, 8'hC3);
        check_regs();
        for (int i = 0; i < 300; i++)
        begin
            wr(sla_pkg::ADR_ACC, (i % 7 == 0) ? 8'h00 : 8'($random(seed)));
            wr(sla_pkg::ADR_FLAGS, 8'($random(seed)));
            wr(sla_pkg::ADR_PORTA, 8'($random(seed)));
            wr(sla_pkg::ADR_IMM, 8'($random(seed)));
            wr(sla_pkg::ADR_MIDX, 8'($random(seed)));
            wr({sla_pkg::ADR_MEM_HI, m_idx}, 8'($random(seed)));
            // two commands in a row so carry and results chain between them
            repeat (2)
            begin
                cmd = legal_q[{$random(seed)} % legal_q.size()];
                if (i % 10 == 9)
                    cmd = bad_cmds[(i / 10) % 5];
                wr(sla_pkg::ADR_CMD, cmd);
                @(negedge sys_clk);
                check_outputs();
            end
            check_regs();
        end
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        m_reset();
        @(negedge sys_clk);
        check_outputs();
        check_regs();
        finish_test();
    end
endmodule
`default_nettype wire
